// File: logic/esc_pkg.sv
/*
 esc_pkg: constants, field positions, command addresses and timing for the encoder serial command link.
 assumes a 200 MHz hclk on both ends.
*/
package esc_pkg;
  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam int FRAME_BITS = 16;
  localparam int DATA_BITS = 14;
  localparam int MSB_POS = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 1;
  localparam int DATA_LO = 2;
  localparam int EF_POS = 1;
  localparam int PAR_POS = 0;
  localparam int IFRST_POS = 2;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_OVER = 5'h11;
  // ****************************************************************
  // fixed command addresses
  // ****************************************************************
  localparam logic [13:0] ADDR_CLR_ERR = 14'h3380;
  localparam logic [13:0] ADDR_SOFT_RST = 14'h3c00;
  localparam logic [13:0] ADDR_NOP = 14'h0000;
  localparam logic [13:0] ADDR_ANGLE = 14'h3fff;
  localparam logic [13:0] DATA_ZERO = 14'h0000;
  localparam logic [15:0] RESP_RESET = 16'h0000;
  // sync order {wire_mode, mosi, ss_n, sclk}; idle select and clock high
  localparam logic [3:0] DEV_SYNC_RST = 4'h3;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SYNC_GAP_NS = 350;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int SYNC_GAP_CYC = (SYNC_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] HALF_LAST = 5'(SCLK_HALF_CYC - 1);
  localparam logic [6:0] GAP_LAST = 7'(SYNC_GAP_CYC - 1);
  // ****************************************************************
  // host registers on AHB-Lite
  // ****************************************************************
  localparam logic [7:0] OFF_TX = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam int ST_PAR_OK = 16;
  localparam int ST_EF = 17;
  localparam int ST_BUSY = 18;
  localparam int ST_DONE = 19;
  typedef enum logic [3:0] {
    ESC_IDLE = 4'h1,
    ESC_LEAD = 4'h2,
    ESC_SHIFT = 4'h4,
    ESC_GAP = 4'h8
  } esc_host_state_type;
endpackage

// File: logic/esc_link_if.sv
/*
 esc_link_if: serial wires between host and device.
 assumes the bench joins both ends; miso is valid only while miso_oe is high.
*/
`timescale 1ns/1ps
interface esc_link_if;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport dev_mp (input sclk, input ss_n, input mosi, output miso, output miso_oe);
  modport host_mp (output sclk, output ss_n, output mosi, input miso, input miso_oe);
endinterface

// File: logic/esc_shift.sv
/*
 esc_shift: loadable msb-first shift register.
 assumes load and shift are single-cycle strobes on clk.
*/
`timescale 1ns/1ps
module esc_shift #(parameter int W = 16)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic shift,
  input wire logic ser_in,
  output logic [W-1:0] q
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else if (load)
      q <= load_val;
    else if (shift)
      q <= {q[W-2:0], ser_in};
  end
endmodule

// File: logic/esc_device.sv
/*
 esc_device: command layer of the encoder's serial slave: frame capture, decode, error flag, soft reset.
 assumes sclk idles high, the host keeps the select gap, register data is returned on reg_rd_data.
*/
`timescale 1ns/1ps
module esc_device
(
  input wire logic hclk,
  input wire logic hresetn,
  esc_link_if.dev_mp link,
  input wire logic wire_mode_pin,
  input wire logic asleep,
  input wire logic [13:0] reg_rd_data,
  output logic [13:0] reg_rd_addr_r,
  output logic reg_wr_r,
  output logic [13:0] reg_wr_addr_r,
  output logic [13:0] reg_wr_data_r,
  output logic transfer_error_flag_r,
  output logic wire_mode_r,
  output logic iface_reset_r,
  output logic osc_start_r,
  output logic [2:0] rst_seq_r,
  output logic trim_load_r
);
  // ****************************************************************
  // input synchronisers and edge detection
  // ****************************************************************
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic sclk_d_r;
  logic ss_d_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= esc_pkg::DEV_SYNC_RST;
      sync2_r <= esc_pkg::DEV_SYNC_RST;
      sclk_d_r <= 1'b1;
      ss_d_r <= 1'b1;
    end
    else
    begin
      sync1_r <= {wire_mode_pin, link.mosi, link.ss_n, link.sclk};
      sync2_r <= sync1_r;
      sclk_d_r <= sync2_r[0];
      ss_d_r <= sync2_r[1];
    end
  end
  wire sclk_s = sync2_r[0];
  wire ss_s = sync2_r[1];
  wire mosi_s = sync2_r[2];
  wire wire_s = sync2_r[3];
  wire active = ~ss_s;
  wire sclk_fall = active & sclk_d_r & ~sclk_s;
  wire sclk_rise = active & ~sclk_d_r & sclk_s;
  wire ss_fall = ss_d_r & ~ss_s;
  wire frame_end = ~ss_d_r & ss_s;
  // ****************************************************************
  // shift registers
  // ****************************************************************
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [15:0] resp_r;
  logic [4:0] bit_cnt_r;
  logic miso_r;
  logic miso_oe_r;
  wire rx_bit = wire_mode_r & mosi_s;
  esc_shift #(.W(esc_pkg::FRAME_BITS)) u_rx
  (
    .clk(hclk),
    .rst_n(hresetn),
    .load(ss_fall),
    .load_val(esc_pkg::RESP_RESET),
    .shift(sclk_fall),
    .ser_in(rx_bit),
    .q(rx_q)
  );
  esc_shift #(.W(esc_pkg::FRAME_BITS)) u_tx
  (
    .clk(hclk),
    .rst_n(hresetn),
    .load(ss_fall),
    .load_val(resp_r),
    .shift(sclk_rise),
    .ser_in(1'b0),
    .q(tx_q)
  );
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bit_cnt_r <= esc_pkg::CNT_ZERO;
    else if (ss_fall)
      bit_cnt_r <= esc_pkg::CNT_ZERO;
    else if (sclk_fall && bit_cnt_r != esc_pkg::CNT_OVER)
      bit_cnt_r <= bit_cnt_r + 5'h01;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      miso_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end
    else
    begin
      miso_r <= active & tx_q[esc_pkg::MSB_POS];
      miso_oe_r <= active;
    end
  end
  assign link.miso = miso_r;
  assign link.miso_oe = miso_oe_r;
  // ****************************************************************
  // frame decode
  // ****************************************************************
  logic wr_pend_r;
  logic [13:0] wr_addr_r;
  wire [13:0] addr = rx_q[esc_pkg::ADDR_HI:esc_pkg::ADDR_LO];
  wire is_read = rx_q[esc_pkg::MSB_POS];
  wire [13:0] rx_data = rx_q[esc_pkg::MSB_POS:esc_pkg::DATA_LO];
  wire cnt_ok = bit_cnt_r == esc_pkg::CNT_FULL;
  wire par_ok = ~^rx_q;
  wire bad_rd = (addr == esc_pkg::ADDR_SOFT_RST) | (addr == esc_pkg::ADDR_NOP);
  wire bad_cmd = ~wr_pend_r & (is_read ? bad_rd : (addr == esc_pkg::ADDR_CLR_ERR));
  wire frame_err = frame_end & (~cnt_ok | (wire_mode_r & (~par_ok | bad_cmd)));
  wire frame_ok = frame_end & ~frame_err;
  wire three_rd = frame_ok & ~wire_mode_r;
  wire data_frame = frame_ok & wire_mode_r & wr_pend_r;
  wire cmd_read = frame_ok & wire_mode_r & ~wr_pend_r & is_read;
  wire cmd_write = frame_ok & wire_mode_r & ~wr_pend_r & ~is_read & (addr != esc_pkg::ADDR_NOP);
  wire clr_cmd = cmd_read & (addr == esc_pkg::ADDR_CLR_ERR);
  wire srst_data = data_frame & (wr_addr_r == esc_pkg::ADDR_SOFT_RST);
  wire if_rst = srst_data & rx_q[esc_pkg::IFRST_POS];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= esc_pkg::ADDR_NOP;
    end
    else if (frame_end)
    begin
      wr_pend_r <= cmd_write;
      wr_addr_r <= cmd_write ? addr : wr_addr_r;
    end
  end
  // ****************************************************************
  // error flag and response build
  // ****************************************************************
  logic rd_pend_r;
  logic build_r;
  logic [13:0] hold_data_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      transfer_error_flag_r <= 1'b0;
    else if (frame_err)
      transfer_error_flag_r <= 1'b1;
    else if (clr_cmd || if_rst)
      transfer_error_flag_r <= 1'b0;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_pend_r <= 1'b0;
      build_r <= 1'b0;
      hold_data_r <= esc_pkg::DATA_ZERO;
      reg_rd_addr_r <= esc_pkg::ADDR_NOP;
    end
    else
    begin
      build_r <= frame_end;
      if (frame_end)
      begin
        rd_pend_r <= (cmd_read & ~clr_cmd) | three_rd;
        hold_data_r <= (data_frame & ~if_rst) ? rx_data : esc_pkg::DATA_ZERO;
        reg_rd_addr_r <= three_rd ? esc_pkg::ADDR_ANGLE : addr;
      end
    end
  end
  wire [13:0] resp_data = rd_pend_r ? reg_rd_data : hold_data_r;
  wire resp_par = ^{resp_data, transfer_error_flag_r};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      resp_r <= esc_pkg::RESP_RESET;
    else if (build_r)
      resp_r <= {resp_data, transfer_error_flag_r, resp_par};
  end
  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reg_wr_r <= 1'b0;
      reg_wr_addr_r <= esc_pkg::ADDR_NOP;
      reg_wr_data_r <= esc_pkg::DATA_ZERO;
    end
    else
    begin
      reg_wr_r <= data_frame & ~srst_data;
      if (data_frame)
      begin
        reg_wr_addr_r <= wr_addr_r;
        reg_wr_data_r <= rx_data;
      end
    end
  end
  // ****************************************************************
  // soft reset sequence, strap and trim load
  // ****************************************************************
  logic [1:0] strap_cnt_r;
  wire por_load = strap_cnt_r == esc_pkg::STRAP_WAIT - 2'h1;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strap_cnt_r <= 2'h0;
      osc_start_r <= 1'b0;
      iface_reset_r <= 1'b0;
      rst_seq_r <= 3'h0;
      trim_load_r <= 1'b0;
      wire_mode_r <= 1'b0;
    end
    else
    begin
      if (strap_cnt_r != esc_pkg::STRAP_WAIT)
        strap_cnt_r <= strap_cnt_r + 2'h1;
      osc_start_r <= srst_data & asleep;
      iface_reset_r <= if_rst;
      rst_seq_r <= {rst_seq_r[1:0], srst_data};
      trim_load_r <= por_load | rst_seq_r[0];
      if (por_load || rst_seq_r[0])
        wire_mode_r <= wire_s;
    end
  end
endmodule

// File: logic/esc_host.sv
/*
 esc_host: serial master for the encoder link, ordered by software over AHB-Lite.
 assumes a single AHB-Lite master, word accesses only; sclk idles high.
*/
`timescale 1ns/1ps
module esc_host
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  esc_link_if.host_mp link
);
  // ****************************************************************
  // bus slave
  // ****************************************************************
  esc_pkg::esc_host_state_type state_r;
  esc_pkg::esc_host_state_type state_nxt;
  logic ph_wr_r;
  logic ph_rd_r;
  logic [7:0] ph_addr_r;
  logic done_r;
  logic sclk_r;
  logic ss_n_r;
  logic [6:0] tick_r;
  logic [4:0] nbit_r;
  logic [1:0] miso_sync_r;
  logic [1:0] oe_sync_r;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  // word transfers only; others complete at once and leave hrdata unchanged
  wire bus_go = hsel & htrans[1] & hready & (hsize == 3'h2);
  wire idle = state_r == esc_pkg::ESC_IDLE;
  // writes while a frame runs are dropped
  wire start_go = ph_wr_r & (ph_addr_r == esc_pkg::OFF_TX) & idle;
  wire [31:0] status_word = {12'h000, done_r, ~idle, rx_q[esc_pkg::EF_POS], ~^rx_q, rx_q};
  wire [31:0] rd_word = (ph_addr_r == esc_pkg::OFF_STATUS) ? status_word : 32'h0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end
    else
    begin
      ph_wr_r <= bus_go & hwrite;
      ph_rd_r <= bus_go & ~hwrite;
      ph_addr_r <= bus_go ? haddr[7:0] : ph_addr_r;
    end
  end
  // one wait state on reads while the status word is registered
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
    end
    else
    begin
      hreadyout <= ~(bus_go & ~hwrite);
      hresp <= 1'b0;
      if (ph_rd_r)
        hrdata <= rd_word;
    end
  end
  // ****************************************************************
  // frame timing
  // ****************************************************************
  wire in_lead = state_r == esc_pkg::ESC_LEAD;
  wire in_shift = state_r == esc_pkg::ESC_SHIFT;
  wire in_gap = state_r == esc_pkg::ESC_GAP;
  wire long_end = tick_r == esc_pkg::GAP_LAST;
  wire half_end = in_shift & (tick_r == {2'h0, esc_pkg::HALF_LAST});
  wire lead_end = in_lead & long_end;
  wire gap_end = in_gap & long_end;
  wire fall_go = lead_end | (half_end & sclk_r);
  wire rise_go = half_end & ~sclk_r;
  wire last_rise = rise_go & (nbit_r == esc_pkg::CNT_FULL);
  wire miso_bit = miso_sync_r[1] & oe_sync_r[1];
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      esc_pkg::ESC_IDLE:
        if (start_go)
          state_nxt = esc_pkg::ESC_LEAD;
      esc_pkg::ESC_LEAD:
        if (lead_end)
          state_nxt = esc_pkg::ESC_SHIFT;
      esc_pkg::ESC_SHIFT:
        if (last_rise)
          state_nxt = esc_pkg::ESC_GAP;
      esc_pkg::ESC_GAP:
        if (gap_end)
          state_nxt = esc_pkg::ESC_IDLE;
      default:
        state_nxt = esc_pkg::ESC_IDLE;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= esc_pkg::ESC_IDLE;
      tick_r <= 7'h00;
      nbit_r <= esc_pkg::CNT_ZERO;
    end
    else
    begin
      state_r <= state_nxt;
      tick_r <= (idle | lead_end | half_end | gap_end) ? 7'h00 : tick_r + 7'h01;
      nbit_r <= start_go ? esc_pkg::CNT_ZERO : nbit_r + {4'h0, fall_go};
    end
  end
  // ****************************************************************
  // link pins
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_r <= 1'b1;
      ss_n_r <= 1'b1;
      done_r <= 1'b0;
      miso_sync_r <= 2'h0;
      oe_sync_r <= 2'h0;
    end
    else
    begin
      if (fall_go)
        sclk_r <= 1'b0;
      else if (rise_go)
        sclk_r <= 1'b1;
      if (start_go)
        ss_n_r <= 1'b0;
      else if (last_rise)
        ss_n_r <= 1'b1;
      if (gap_end)
        done_r <= 1'b1;
      else if (start_go)
        done_r <= 1'b0;
      miso_sync_r <= {miso_sync_r[0], link.miso};
      oe_sync_r <= {oe_sync_r[0], link.miso_oe};
    end
  end
  esc_shift #(.W(esc_pkg::FRAME_BITS)) u_tx
  (
    .clk(hclk),
    .rst_n(hresetn),
    .load(start_go),
    .load_val(hwdata[esc_pkg::MSB_POS:esc_pkg::PAR_POS]),
    .shift(rise_go),
    .ser_in(1'b0),
    .q(tx_q)
  );
  esc_shift #(.W(esc_pkg::FRAME_BITS)) u_rx
  (
    .clk(hclk),
    .rst_n(hresetn),
    .load(start_go),
    .load_val(esc_pkg::RESP_RESET),
    .shift(fall_go),
    .ser_in(miso_bit),
    .q(rx_q)
  );
  assign link.sclk = sclk_r;
  assign link.ss_n = ss_n_r;
  assign link.mosi = tx_q[esc_pkg::MSB_POS];
endmodule

// File: tb/esc_properties.sv
/*
 esc_properties: concurrent checks on the serial link wires.
 assumes it is instantiated beside the link interface in the bench top.
*/
`timescale 1ns/1ps
module esc_properties
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // ****
  // falling sclk edges per frame
  // ****
  logic sclk_d_r;
  logic [4:0] n_fall_r;
  logic [4:0] n_fall_nxt;
  assign n_fall_nxt = ss_n ? 5'h00 : n_fall_r + {4'h0, sclk_d_r & ~sclk};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_d_r <= 1'b1;
      n_fall_r <= 5'h00;
    end
    else
    begin
      sclk_d_r <= sclk;
      n_fall_r <= n_fall_nxt;
    end
  end
  // ****
  // properties
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  clk_idle_high_a: assert property (ss_n |-> sclk) else $error("sclk low while deselected");
  miso_release_a: assert property (ss_n[*4] |-> !miso_oe) else $error("miso driven while deselected");
  mosi_steady_a: assert property (!ss_n && $fell(sclk) |-> $stable(mosi)) else $error("mosi moved at sample");
  miso_steady_a: assert property (!ss_n && $fell(sclk) |-> $stable(miso)) else $error("miso moved at fall");
  sixteen_clk_a: assert property ($rose(ss_n) |-> n_fall_r == esc_pkg::CNT_FULL)
    else $error("frame clock count wrong");
  select_lead_a: assert property ($fell(ss_n) |-> sclk[*8] ##1 sclk[*8]) else $error("select lead short");
  deselect_gap_a: assert property ($rose(ss_n) |-> ss_n[*8] ##1 ss_n[*8]) else $error("frame gap short");
  driven_frame_a: assert property ($fell(ss_n) |-> ##[1:16] miso_oe) else $error("miso not driven");
  cover property ($rose(ss_n) && n_fall_r == esc_pkg::CNT_FULL);
  cover property (!ss_n && $fell(sclk) && mosi);
  cover property ($fell(ss_n));
endmodule

// File: tb/encoder_spi_command_slave_tb_top.sv
/*
 encoder_spi_command_slave_tb_top: host and device joined, host ordered over AHB-Lite.
 assumes the status word carries the last received frame in bits 15:0.
*/
`timescale 1ns/1ps
module encoder_spi_command_slave_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, transfer_error_flag_r, wire_mode_r, iface_reset_r, osc_start_r, trim_load_r, reg_wr_r;
  logic [31:0] hrdata;
  logic wire_mode_pin = 1'b1;
  logic asleep = 1'b0;
  logic [13:0] reg_rd_data, reg_rd_addr_r, reg_wr_addr_r, reg_wr_data_r;
  logic [15:0] rx;
  logic [1:0] seen = 2'h0;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_trim = 0;
  int n_wr = 0;
  assign reg_rd_data = reg_rd_addr_r ^ 14'h1555;
  always #2.5 hclk = ~hclk;
  esc_link_if i_esc_link_if ();
  esc_host i_esc_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .link(i_esc_link_if.host_mp));
  esc_device i_esc_device (.hclk(hclk), .hresetn(hresetn), .link(i_esc_link_if.dev_mp),
    .wire_mode_pin(wire_mode_pin), .asleep(asleep), .reg_rd_data(reg_rd_data), .reg_rd_addr_r(reg_rd_addr_r),
    .reg_wr_r(reg_wr_r), .reg_wr_addr_r(reg_wr_addr_r), .reg_wr_data_r(reg_wr_data_r),
    .transfer_error_flag_r(transfer_error_flag_r), .wire_mode_r(wire_mode_r), .iface_reset_r(iface_reset_r),
    .osc_start_r(osc_start_r), .rst_seq_r(), .trim_load_r(trim_load_r));
  esc_properties i_esc_properties (.hclk(hclk), .hresetn(hresetn), .sclk(i_esc_link_if.sclk),
    .ss_n(i_esc_link_if.ss_n), .mosi(i_esc_link_if.mosi), .miso(i_esc_link_if.miso),
    .miso_oe(i_esc_link_if.miso_oe));
  // ****
  // shared tasks
  // ****
  function automatic logic [15:0] fr(input logic [14:0] u);
    return {u, ^u};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic xfer(input logic [15:0] tx);
    logic [31:0] q;
    ahb(1'b1, esc_pkg::OFF_TX, {16'h0, tx}, q);
    repeat (4) @(posedge hclk);
    q = 32'h0;
    while (q[esc_pkg::ST_DONE] !== 1'b1 || q[esc_pkg::ST_BUSY] !== 1'b0)
      ahb(1'b0, esc_pkg::OFF_STATUS, 32'h0, q);
    rx = q[15:0];
  endtask
  task automatic tally_and_finish;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (trim_load_r === 1'b1)
      n_trim++;
    if (reg_wr_r === 1'b1)
      n_wr++;
    seen <= seen | {osc_start_r === 1'b1, iface_reset_r === 1'b1};
    if (cyc == 60000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end
  // ****
  // scenarios
  // ****
  task automatic t_nop;
    logic [31:0] q;
    ahb(1'b0, 8'h08, 32'h0, q);
    xfer(16'h0);
    xfer(16'h0);
    chk(rx, 32'h0, "nop answer");
    chk(32'(n_trim > 0), 32'h1, "power-on trim");
  endtask
  task automatic t_read;
    xfer(fr({1'b1, 14'h0123}));
    xfer(fr({1'b1, esc_pkg::ADDR_ANGLE}));
    chk(rx, fr({14'h0123 ^ 14'h1555, 1'b0}), "read one");
    xfer(16'h0);
    chk(rx, fr({esc_pkg::ADDR_ANGLE ^ 14'h1555, 1'b0}), "read two");
  endtask
  task automatic t_write;
    xfer(fr({1'b0, 14'h0155}));
    xfer(fr({14'h2aaa, 1'b0}));
    xfer(16'h0);
    chk(rx, fr({14'h2aaa, 1'b0}), "echo");
    chk(reg_wr_addr_r, 14'h0155, "write addr");
    chk(reg_wr_data_r, 14'h2aaa, "write data");
    chk(n_wr, 32'h1, "one write");
  endtask
  task automatic t_err;
    xfer(fr({1'b1, 14'h0200}) ^ 16'h0001);
    xfer(16'h0);
    chk(rx[1], 1'b1, "flag bit");
    chk(transfer_error_flag_r, 1'b1, "flag");
    xfer(16'h0);
    chk(rx[1], 1'b1, "flag sticks");
    xfer(fr({1'b1, esc_pkg::ADDR_CLR_ERR}));
    xfer(16'h0);
    chk(rx[15:2], 14'h0, "clear data");
    chk(transfer_error_flag_r, 1'b0, "flag cleared");
    xfer(16'h0);
    chk(rx, 32'h0, "clean nop");
  endtask
  task automatic t_soft;
    int k;
    int w;
    k = n_trim;
    w = n_wr;
    chk(wire_mode_r, 1'b1, "mode four");
    wire_mode_pin <= 1'b0;
    xfer(16'h0);
    chk(wire_mode_r, 1'b1, "mode held");
    asleep <= 1'b1;
    xfer(fr({1'b0, esc_pkg::ADDR_SOFT_RST}));
    xfer(fr(15'h0002));
    for (int i = 0; i < 400 && wire_mode_r !== 1'b0; i++)
      @(posedge hclk);
    chk(wire_mode_r, 1'b0, "mode three");
    chk(32'(n_trim > k), 32'h1, "trim reload");
    chk(seen, 2'h3, "osc and iface reset");
    chk(n_wr, w, "no write on reset");
    // external reset from three-wire mode, pin back to four-wire
    wire_mode_pin <= 1'b1;
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(wire_mode_r, 1'b1, "mode after reset");
    chk(transfer_error_flag_r, 1'b0, "flag after reset");
    xfer(16'h0);
    chk(rx, 32'h0, "nop after reset");
  endtask
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_nop;
    t_read;
    t_write;
    t_err;
    t_soft;
    tally_and_finish;
  end
endmodule
